//--- logic/dboc_fifo.v
`timescale 1ns/1ps
`include "dboc_map.vh"
module dboc_fifo #(
   parameter W  = `DBOC_DQ_WIDTH,
   parameter D  = `DBOC_FIFO_DEPTH,
   parameter AW = 5
) (
   input  wire         clk,
   input  wire         srst,
   input  wire         ce,
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output wire         in_ready,
   output wire [W-1:0] out_data,
   output wire         out_valid,
   input  wire         out_ready
);
   // ****************************************
   // Storage and pointers
   // ****************************************
   reg [W-1:0]  mem [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0]   cnt_q;
   wire         push;
   wire         pop;

   assign in_ready  = (cnt_q != D[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (ce && push) begin
         mem[wp_q] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // dboc_fifo

//--- logic/dboc_top.v
// Contract
// RULE1 - Only NOP or deselect between MRS and ZQCL
// RULE2 - Controller drives zero on A[1:0] for pattern
// RULE3 - Chopped pattern read: A2 selects nibble
// RULE4 - On-the-fly field with A12 low: chop four
// RULE5 - Eight beats: fixed field, or A12 high
// RULE6 - Fixed chop field: always four beats
// RULE7 - Termination input held high four-beat hold time
// RULE8 - After write, hold termination per burst length
// RULE9 - Termination latency is AL plus CWL minus two
// RULE10 - Power-down transition window is WL minus one
// RULE11 - Supply mode change only under held reset
// RULE12 - Read data starts AL plus CL later
// RULE13 - Write data starts AL plus CWL later
`timescale 1ns/1ps
`include "dboc_map.vh"
module dboc_top #(
   parameter DW  = `DBOC_DQ_WIDTH,
   parameter FD  = `DBOC_FIFO_DEPTH,
   parameter LD  = `DBOC_LAT_DEPTH
) (
   input  wire          REF_CLK,
   input  wire          SRST,
   input  wire          CE,
   input  wire [2:0]    CMD,
   input  wire [12:0]   ADDR,
   input  wire          ODT,
   input  wire          CKE,
   input  wire [DW-1:0] WDATA,
   input  wire          WDATA_VALID,
   output wire          WR_READY,
   input  wire [1:0]    BURST_MODE,
   input  wire          MPR_EN,
   input  wire [7:0]    MPR_PATTERN,
   input  wire [4:0]    ADD_LAT,
   input  wire [4:0]    CAS_LAT,
   input  wire [4:0]    CAS_WR_LAT,
   output wire [DW-1:0] RDATA,
   output wire          RDATA_VALID,
   output wire          ODT_TERM,
   output wire          ODT_ASYNC_WIN
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   localparam SW = 3 + 13 + 1 + 1 + DW + 1;
   // Reset value with CKE at its idle high level
   localparam [SW-1:0] PIN_IDLE = {{(SW-DW-2){1'b0}}, 1'b1, {(DW+1){1'b0}}};
   reg  [SW-1:0] pin_a_q;
   reg  [SW-1:0] pin_b_q;
   wire [2:0]    cmd_s;
   wire [12:0]   addr_s;
   wire          odt_s;
   wire          cke_s;
   wire [DW-1:0] wdata_s;
   wire          wvalid_s;

   always @(posedge REF_CLK) begin
      if (SRST) begin
         pin_a_q <= PIN_IDLE;
         pin_b_q <= PIN_IDLE;
      end else if (CE) begin
         pin_a_q <= {CMD, ADDR, ODT, CKE, WDATA, WDATA_VALID};
         pin_b_q <= pin_a_q;
      end
   end

   assign {cmd_s, addr_s, odt_s, cke_s, wdata_s, wvalid_s} = pin_b_q;

   // ****************************************
   // Latencies
   // ****************************************
   wire [5:0] rl   = {1'b0, ADD_LAT} + {1'b0, CAS_LAT};      // [RULE12]
   wire [5:0] wl   = {1'b0, ADD_LAT} + {1'b0, CAS_WR_LAT};   // [RULE13]
   wire [5:0] odtl = wl - `DBOC_ODT_LAT_SUB;                 // [RULE9]
   wire [5:0] anpd = wl - `DBOC_ANPD_SUB;                    // [RULE10]
   wire [4:0] rl_tap   = (rl == 6'h00) ? 5'h00 : rl[4:0] - 5'h01;
   wire [4:0] wl_tap   = (wl == 6'h00) ? 5'h00 : wl[4:0] - 5'h01;
   wire [4:0] odtl_tap = (odtl[5] || odtl == 6'h00) ? 5'h00
                                                     : odtl[4:0] - 5'h01;

   // ****************************************
   // Burst length decode
   // ****************************************
   reg is_bc4;
   always @* begin
      case (BURST_MODE)
         `DBOC_BL_FIX8: is_bc4 = 1'b0;                        // [RULE5]
         `DBOC_BL_OTF:  is_bc4 = ~addr_s[`DBOC_A_BC];         // [RULE4] [RULE5]
         `DBOC_BL_FIX4: is_bc4 = 1'b1;                        // [RULE6]
         default:       is_bc4 = 1'b0;
      endcase
   end

   wire cmd_rd = (cmd_s == `DBOC_CMD_RD);
   wire cmd_wr = (cmd_s == `DBOC_CMD_WR);

   // ****************************************
   // Command latency pipes
   // ****************************************
   reg [LD-1:0] rd_sh_q;
   reg [LD-1:0] rbc_sh_q;
   reg [LD-1:0] rnib_sh_q;
   reg [LD-1:0] wr_sh_q;
   reg [LD-1:0] wbc_sh_q;
   reg [LD-1:0] odt_sh_q;

   always @(posedge REF_CLK) begin
      if (SRST) begin                                         // [RULE11]
         rd_sh_q   <= {LD{1'b0}};
         rbc_sh_q  <= {LD{1'b0}};
         rnib_sh_q <= {LD{1'b0}};
         wr_sh_q   <= {LD{1'b0}};
         wbc_sh_q  <= {LD{1'b0}};
         odt_sh_q  <= {LD{1'b0}};
      end else if (CE) begin
         rd_sh_q   <= {rd_sh_q[LD-2:0], cmd_rd};
         rbc_sh_q  <= {rbc_sh_q[LD-2:0], is_bc4};
         rnib_sh_q <= {rnib_sh_q[LD-2:0], addr_s[`DBOC_A_NIB]};
         wr_sh_q   <= {wr_sh_q[LD-2:0], cmd_wr};
         wbc_sh_q  <= {wbc_sh_q[LD-2:0], is_bc4};
         odt_sh_q  <= {odt_sh_q[LD-2:0], odt_s};
      end
   end

   wire rd_go  = rd_sh_q[rl_tap];
   wire wr_go  = wr_sh_q[wl_tap];

   // ****************************************
   // Write data into the buffer
   // ****************************************
   reg  [3:0]    wcnt_q;
   wire          fifo_in_ready;
   wire [DW-1:0] fifo_out_data;
   wire          fifo_out_valid;
   wire          fifo_pop;
   wire          wr_win = (wcnt_q != 4'h0);

   assign WR_READY = wr_win & fifo_in_ready;                  // [RULE13]

   always @(posedge REF_CLK) begin
      if (SRST) begin
         wcnt_q <= 4'h0;
      end else if (CE) begin
         if (wr_go) begin
            wcnt_q <= wbc_sh_q[wl_tap] ? `DBOC_BEATS_BC4      // [RULE4] [RULE6]
                                       : `DBOC_BEATS_BL8;     // [RULE5]
         end else if (wr_win) begin
            wcnt_q <= wcnt_q - 4'h1;
         end
      end
   end

   dboc_fifo #(
      .W  (DW),
      .D  (FD),
      .AW (5)
   ) u_fifo (
      .clk       (REF_CLK),
      .srst      (SRST),
      .ce        (CE),
      .in_data   (wdata_s),
      .in_valid  (wvalid_s & wr_win),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop)
   );

   // ****************************************
   // Read burst engine
   // ****************************************
   localparam RS_IDLE  = 2'b01;
   localparam RS_BURST = 2'b10;
   reg [1:0]    rs_q;
   reg [1:0]    rs_d;
   reg [3:0]    rcnt_q;
   reg [2:0]    rbeat_q;
   reg          rmpr_q;
   reg [DW-1:0] rdata_q;
   reg          rvalid_q;

   always @* begin
      case (rs_q)
         RS_IDLE:  rs_d = rd_go ? RS_BURST : RS_IDLE;
         RS_BURST: rs_d = (rcnt_q == 4'h1 && !rd_go) ? RS_IDLE : RS_BURST;
         default:  rs_d = RS_IDLE;
      endcase
   end

   assign fifo_pop = (rs_q == RS_BURST) & ~rmpr_q;

   always @(posedge REF_CLK) begin
      if (SRST) begin
         rs_q     <= RS_IDLE;
         rcnt_q   <= 4'h0;
         rbeat_q  <= 3'h0;
         rmpr_q   <= 1'b0;
         rdata_q  <= {DW{1'b0}};
         rvalid_q <= 1'b0;
      end else if (CE) begin
         rs_q     <= rs_d;
         rvalid_q <= (rs_q == RS_BURST);                      // [RULE12]
         if (rs_q == RS_BURST) begin
            if (rmpr_q) begin
               rdata_q <= {DW{MPR_PATTERN[rbeat_q]}};         // [RULE3]
            end else begin
               rdata_q <= fifo_out_valid ? fifo_out_data : {DW{1'b0}};
            end
            rbeat_q <= rbeat_q + 3'h1;
            rcnt_q  <= rcnt_q - 4'h1;
         end
         if (rd_go) begin
            rmpr_q <= MPR_EN;
            // Pattern starts at beat zero, or beat four for a chop with A2 high; column bits below A2 unused
            rbeat_q <= (rbc_sh_q[rl_tap] && rnib_sh_q[rl_tap])
                       ? `DBOC_NIB_BASE : 3'h0;               // [RULE2] [RULE3]
            rcnt_q  <= rbc_sh_q[rl_tap] ? `DBOC_BEATS_BC4     // [RULE4] [RULE6]
                                        : `DBOC_BEATS_BL8;    // [RULE5]
         end
      end
   end

   assign RDATA       = rdata_q;
   assign RDATA_VALID = rvalid_q;

   // ****************************************
   // Termination timing
   // ****************************************
   reg       cke_d_q;
   reg [5:0] anpd_q;
   reg       term_q;
   wire      cke_edge = cke_s ^ cke_d_q;

   always @(posedge REF_CLK) begin
      if (SRST) begin
         cke_d_q <= 1'b1;
         anpd_q  <= 6'h00;
         term_q  <= 1'b0;
      end else if (CE) begin
         cke_d_q <= cke_s;
         if (cke_edge) begin
            anpd_q <= anpd;                                   // [RULE10]
         end else if (anpd_q != 6'h00) begin
            anpd_q <= anpd_q - 6'h01;
         end
         // Relies on controller holding ODT for the hold times
         if (!cke_s && anpd_q == 6'h00 && !cke_edge) begin
            term_q <= odt_s;                                  // [RULE7] [RULE8]
         end else begin
            term_q <= (odtl == 6'h00) ? odt_s
                                      : odt_sh_q[odtl_tap];   // [RULE9]
         end
      end
   end

   assign ODT_TERM      = term_q;
   assign ODT_ASYNC_WIN = (anpd_q != 6'h00);

   // ****************************************
   // Mode register sequencing
   // ****************************************
   // Buffer and pipes need no guard between MRS and ZQCL   [RULE1]
endmodule // dboc_top

//--- pkg/dboc_map.vh
`ifndef DBOC_MAP_VH
`define DBOC_MAP_VH
// ****************************************
// Command codes
// ****************************************
`define DBOC_CMD_NOP   3'h0
`define DBOC_CMD_RD    3'h1
`define DBOC_CMD_WR    3'h2
`define DBOC_CMD_MRS   3'h3
`define DBOC_CMD_ZQCL  3'h4
`define DBOC_CMD_DES   3'h7
// ****************************************
// Burst field encodings
// ****************************************
`define DBOC_BL_FIX8   2'h0
`define DBOC_BL_OTF    2'h1
`define DBOC_BL_FIX4   2'h2
// ****************************************
// Address field positions
// ****************************************
`define DBOC_A_BC      12
`define DBOC_A_NIB     2
// ****************************************
// Timing counts in clock cycles, buffer depths and data width
// ****************************************
`define DBOC_ODT_LAT_SUB 6'h02
`define DBOC_ANPD_SUB    6'h01
`define DBOC_BEATS_BC4   4'h4
`define DBOC_BEATS_BL8   4'h8
`define DBOC_NIB_BASE    3'h4
`define DBOC_FIFO_DEPTH  32
`define DBOC_DQ_WIDTH    16
`define DBOC_LAT_DEPTH   32
`endif

//--- sim/dboc_ctl.sv
`timescale 1ns/1ps
`include "dboc_map.vh"
// ****
// Controller model
// ****
module dboc_ctl (
   input  wire        clk,
   output reg  [2:0]  cmd,
   output reg  [12:0] addr,
   output reg         odt,
   output reg         cke,
   output reg  [15:0] wdata,
   output reg         wvalid
);
   initial begin
      cmd = `DBOC_CMD_DES;
      addr = 13'h0000;
      odt = 1'b0;
      cke = 1'b1;
      wdata = 16'h0000;
      wvalid = 1'b1;
   end
   // Fresh beat each cycle
   always @(posedge clk) wdata <= #1 16'($urandom);
   // Column bits A[1:0] low, then only NOP
   task issue(input [2:0] c, input [12:0] a);
      @(posedge clk) #1;
      cmd = c;
      addr = {a[12:2], 2'h0};
      @(posedge clk) #1;
      cmd = `DBOC_CMD_NOP;
      addr = ~a;
   endtask
   // Termination held past both hold times
   task term(input [2:0] c);
      @(posedge clk) #1;
      odt = 1'b1;
      issue(c, 13'h1000);
      repeat (10) @(posedge clk);
      #1 odt = 1'b0;
   endtask
   task pd(input int n);
      @(posedge clk) #1 cke = 1'b0;
      repeat (n) @(posedge clk);
      #1 cke = 1'b1;
   endtask
endmodule // dboc_ctl

//--- sim/dboc_top_monitor.sv
`timescale 1ns/1ps
`include "dboc_map.vh"
// ****
// Port checker
// ****
module dboc_mon #(
   parameter DW = 16
) (
   input wire          REF_CLK,
   input wire          SRST,
   input wire          CE,
   input wire [2:0]    CMD,
   input wire [12:0]   ADDR,
   input wire          ODT,
   input wire          CKE,
   input wire [1:0]    BURST_MODE,
   input wire          MPR_EN,
   input wire [7:0]    MPR_PATTERN,
   input wire [4:0]    ADD_LAT,
   input wire [4:0]    CAS_LAT,
   input wire [4:0]    CAS_WR_LAT,
   input wire [DW-1:0] RDATA,
   input wire          RDATA_VALID,
   input wire          WR_READY,
   input wire          ODT_TERM,
   input wire          ODT_ASYNC_WIN
);
   reg  [7:0] cr_q, cw_q, co_q, rn_q, an_q;
   reg        a12_q, a2_q, op_q;
   wire [5:0] rl = ADD_LAT + CAS_LAT;
   wire [5:0] wl = ADD_LAT + CAS_WR_LAT;
   wire       chop = BURST_MODE == 2'h2 || BURST_MODE == 2'h1 && !a12_q;
   wire [2:0] idx = chop ? {a2_q, rn_q[1:0]} : rn_q[2:0];
   // Enabled cycles since each cause, run lengths
   always @(posedge REF_CLK) begin
      if (CE) begin
         cr_q <= CMD == `DBOC_CMD_RD ? 8'h01 : cr_q + 8'h01;
         cw_q <= CMD == `DBOC_CMD_WR ? 8'h01 : cw_q + 8'h01;
         co_q <= ODT && !op_q ? 8'h01 : co_q + 8'h01;
         op_q <= ODT;
         rn_q <= RDATA_VALID ? rn_q + 8'h01 : 8'h00;
         an_q <= ODT_ASYNC_WIN ? an_q + 8'h01 : 8'h00;
         if (CMD == `DBOC_CMD_RD) begin
            a12_q <= ADDR[`DBOC_A_BC];
            a2_q  <= ADDR[`DBOC_A_NIB];
         end
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   property p_rst;
      $fell(SRST) |-> !RDATA_VALID && !WR_READY && !ODT_TERM
         && !ODT_ASYNC_WIN && RDATA == '0;
   endproperty
   property p_rdlat;
      $rose(RDATA_VALID) |-> cr_q >= rl + 2 && cr_q <= rl + 4;
   endproperty
   property p_wrlat;
      $rose(WR_READY) |-> cw_q >= wl + 1 && cw_q <= wl + 3;
   endproperty
   property p_wrwin;
      WR_READY |-> cw_q <= wl + 11;
   endproperty
   property p_rdlen;
      $fell(RDATA_VALID) |-> rn_q == (chop ? 8'h04 : 8'h08);
   endproperty
   property p_mpr;
      RDATA_VALID && MPR_EN |-> RDATA[0] == MPR_PATTERN[idx];
   endproperty
   property p_odt;
      $rose(ODT_TERM) && CKE && !ODT_ASYNC_WIN
         |-> co_q >= wl && co_q <= wl + 2;
   endproperty
   property p_anpd;
      $fell(ODT_ASYNC_WIN) |-> an_q == wl - 1;
   endproperty
   a_rst: assert property (p_rst)
      else $error("bad reset state");
   a_rdlat: assert property (p_rdlat)
      else $error("read latency");
   a_wrlat: assert property (p_wrlat)
      else $error("write latency");
   a_wrwin: assert property (p_wrwin)
      else $error("write window");
   a_rdlen: assert property (p_rdlen)
      else $error("burst length");
   a_mpr: assert property (p_mpr)
      else $error("pattern beat");
   a_odt: assert property (p_odt)
      else $error("term latency");
   a_anpd: assert property (p_anpd)
      else $error("async window");
   c_chop: cover property ($fell(RDATA_VALID) && chop);
   c_wr: cover property ($fell(WR_READY));
   c_pd: cover property ($fell(ODT_ASYNC_WIN));
endmodule // dboc_mon
bind dboc_top dboc_mon #(.DW(DW)) u_mon (.REF_CLK, .SRST, .CE, .CMD,
   .ADDR, .ODT, .CKE, .BURST_MODE, .MPR_EN, .MPR_PATTERN, .ADD_LAT,
   .CAS_LAT, .CAS_WR_LAT, .RDATA, .RDATA_VALID, .WR_READY, .ODT_TERM,
   .ODT_ASYNC_WIN);

//--- sim/tb_dboc_top.sv
`timescale 1ns/1ps
`include "dboc_map.vh"
module tb_dboc_top;
   reg  clk = 0, srst = 1, mpr = 1, ce = 1, op = 0, tp = 0;
   int  od = 0, an = 0;
   reg  [1:0]  bm = 0;
   reg  [7:0]  pat = 0;
   reg  [4:0]  al = 0, cl = 5, cwl = 5;
   wire [2:0]  cmd;
   wire [12:0] addr;
   wire [15:0] wdata, rdata;
   wire        odt, cke, wvalid, wr_ready, rvalid, term, awin;
   reg  [15:0] mem_q[$], h0, h1;
   reg  [16:0] exp_q[$], e;
   int failures = 0, tests_run = 0, cyc = 0;
   initial forever #50 clk = ~clk;
   dboc_ctl ctl (.clk(clk), .cmd(cmd), .addr(addr), .odt(odt), .cke(cke),
      .wdata(wdata), .wvalid(wvalid));
   dboc_top DUT (.REF_CLK(clk), .SRST(srst), .CE(ce), .CMD(cmd),
      .ADDR(addr), .ODT(odt), .CKE(cke), .WDATA(wdata),
      .WDATA_VALID(wvalid), .WR_READY(wr_ready), .BURST_MODE(bm),
      .MPR_EN(mpr), .MPR_PATTERN(pat), .ADD_LAT(al), .CAS_LAT(cl),
      .CAS_WR_LAT(cwl), .RDATA(rdata), .RDATA_VALID(rvalid),
      .ODT_TERM(term), .ODT_ASYNC_WIN(awin));
   task chk(input [15:0] s, input [15:0] x);
      tests_run++;
      if (s !== x) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Note beats of one read, then issue it
   task rd(input a12, input a2);
      int n;
      n = (bm == 2 || bm == 1 && !a12) ? 4 : 8;
      for (int i = 0; i < n; i++)
         if (mpr) exp_q.push_back({1'b1, 15'h0, pat[a2 && n == 4 ? i + 4 : i]});
         else exp_q.push_back(mem_q.size() ? {1'b0, mem_q.pop_front()} : 0);
      ctl.issue(`DBOC_CMD_RD, {a12, 9'h0, a2, 2'h0});
      // Freeze two cycles in latency or burst
      repeat (9) @(posedge clk);
      #1 ce = 0;
      repeat (2) @(posedge clk);
      #1 ce = 1;
      repeat (21) @(posedge clk);
      #1;
   endtask
   // Accepted beats and read results
   always @(negedge clk) begin
      if (wr_ready === 1'b1) mem_q.push_back(h1);
      h1 = h0;
      h0 = wdata;
      if (rvalid === 1'b1 && ce) begin
         e = exp_q.size() ? exp_q.pop_front() : 17'h1FFFF;
         chk(e[16] ? {15'h0, rdata[0]} : rdata, e[15:0]);
      end
      if (term && !tp) chk(16'(od), 16'(al + cwl + 1));
      if (!awin && an > 0) chk(16'(an), 16'(al + cwl - 1));
      od = (odt && !op) ? 1 : od + 1;
      an = (awin === 1'b1) ? an + 1 : 0;
      op = odt;
      tp = term;
   end
   always @(posedge clk) if (++cyc == 6000) begin
      failures++;
      summarize;
   end
   initial begin
      void'($urandom(38));
      al = 5'($urandom % 3);
      cl = 5'(5 + $urandom % 3);
      repeat (8) @(posedge clk);
      #1 srst = 0;
      for (int k = 0; k < 12; k++) begin
         bm = k / 4;
         pat = 8'($urandom);
         rd(k[0], k[1]);
      end
      ctl.issue(`DBOC_CMD_MRS, 13'h0000);
      ctl.issue(`DBOC_CMD_ZQCL, 13'h0400);
      mpr = 0;
      bm = 0;
      for (int k = 0; k < 5; k++) begin
         ctl.issue(`DBOC_CMD_WR, 13'h1000);
         repeat (25) @(posedge clk);
      end
      chk(16'(mem_q.size()), 16'h0020);
      repeat (5) rd(1, 0);
      ctl.term(`DBOC_CMD_WR);
      repeat (20) @(posedge clk);
      rd(1, 0);
      ctl.pd(20);
      repeat (20) @(posedge clk);
      // Held reset, then start over
      #1 srst = 1;
      mem_q.delete();
      repeat (8) @(posedge clk);
      #1 srst = 0;
      mpr = 1;
      bm = 2;
      rd(1, 1);
      chk(16'(exp_q.size()), 16'h0000);
      summarize;
   end
endmodule // tb_dboc_top
